// *** scs_pkg.sv ***
// Shared constants, states and carriers for the clock-stop serial port
package scs_pkg;

  // Default widths
  localparam int SCS_DIVIDE_WIDTH = 8;
  localparam int SCS_WORD_WIDTH = 8;

  // Clock-stop mode encodings; bit 1 enables clock-stop operation
  localparam logic [1:0] SCS_MODE_CHANGE_RISE = 2'h2;
  localparam logic [1:0] SCS_MODE_CHANGE_FALL = 2'h3;
  localparam int SCS_MODE_ENABLE_BIT = 1;
  localparam int SCS_MODE_FALL_BIT = 0;

  // Generator source select: 1 takes the CPU clock, 0 the reference pin
  localparam logic SCS_SRC_CPU = 1'h1;
  // Input period S is two CPU periods, so one half-S is one clk_sys cycle
  localparam int SCS_CPU_PERIODS_PER_S = 2;
  localparam int SCS_CPU_HALF_S_CYCLES = SCS_CPU_PERIODS_PER_S / 2;

  // Half-S step added to the divide value for the high phase length
  localparam int SCS_HIGH_ADD_EVEN = 2;
  localparam int SCS_HIGH_ADD_ODD = 1;

  // First-bit extra delay, in CPU periods; clk_sys is the CPU clock
  localparam int SCS_EXTRA_DELAY_MIN_P = 2;
  localparam int SCS_EXTRA_DELAY_MAX_P = 4;
  localparam int SCS_EXTRA_DELAY_CYCLES = (SCS_EXTRA_DELAY_MIN_P + SCS_EXTRA_DELAY_MAX_P) / 2;
  localparam int SCS_DELAY_CNT_WIDTH = 3;

  // Transfer states, Gray coded along idle, lead, shift, tail
  typedef enum logic [1:0] {
    SCS_IDLE = 2'h0,
    SCS_LEAD = 2'h1,
    SCS_SHIFT = 2'h3,
    SCS_TAIL = 2'h2
  } scs_state_e;

  // Port configuration as software sets it
  typedef struct packed {
    logic srgSourceSelect;
    logic [SCS_DIVIDE_WIDTH-1:0] srgDivideValue;
    logic txExtraDelayEnable;
    logic [1:0] clockStopMode;
    logic txClockPolarity;
    logic rxSyncPolarity;
    logic txSyncPolarity;
    logic txClockDirection;
    logic rxClockDirection;
    logic txSyncDirection;
    logic rxSyncDirection;
  } scs_config_s;

  // One driven pin: level and output enable
  typedef struct packed {
    logic value;
    logic enable;
  } scs_pin_out_s;

endpackage : scs_pkg

// *** scs_spi_port.sv ***
// Clock-stop (SPI-compatible) serial port: bit clock generator, master and slave transfer
//
// Notes on behaviour
// - Generator input period is two CPU clocks, or one reference clock period.
// - Bit clock period equals divide value plus one input periods.
// - Even nonzero divide: high phase lasts divide/2 plus one periods.
// - Even nonzero divide: low phase lasts divide/2 periods.
// - Odd or zero divide: high and low each last (divide+1)/2 periods.
// - Extra delay, when enabled, applies only to the first transmitted bit.
// - Extra delay is zero when disabled, two to four CPU clocks when enabled.
// - Master with both sync polarities set drives an active-low select.
// - Slave inverts the active-low select on both frame-sync pins.
// - Master drives select low before the enabling rising clock edge.
// - Mode 10b: change on rise, sample on fall, select margins as given.
// - Mode 11b: change on fall, sample on rise, select margins as given.
// - Master releases data: mode 10b one low phase late, 11b at fall.
// - Slave releases data shortly after its select returns high.
`timescale 1ns/10ps
module scs_spi_port #(
  parameter int WORD_WIDTH = scs_pkg::SCS_WORD_WIDTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire scs_pkg::scs_config_s portConfig,
  input wire logic srgRefClockIn,
  input wire logic [WORD_WIDTH-1:0] txData,
  input wire logic txValid,
  output logic txReady,
  output logic [WORD_WIDTH-1:0] rxData,
  output logic rxValid,
  output logic busy,
  input wire logic transmitBitClockIn,
  output scs_pkg::scs_pin_out_s transmitBitClockOut,
  input wire logic transmitFrameSyncIn,
  output scs_pkg::scs_pin_out_s transmitFrameSyncOut,
  input wire logic receiveFrameSyncIn,
  output scs_pkg::scs_pin_out_s serialDataOut,
  input wire logic serialDataIn
);
  import scs_pkg::*;

  localparam int DW = SCS_DIVIDE_WIDTH;
  localparam int CW = $clog2(WORD_WIDTH + 1);
  localparam logic [CW-1:0] LAST_BIT = CW'(WORD_WIDTH - 1);
  localparam logic [CW-1:0] ALL_BITS = CW'(WORD_WIDTH);

  // Refuse word widths the shifters cannot serve
  if (WORD_WIDTH < 2) begin : g_width_check
    $error("scs_spi_port: WORD_WIDTH must be at least 2");
  end

  // Gated view of the configuration
  logic portOn;
  logic modeFall;
  logic isMaster;
  logic isSlave;
  logic bothSyncPol;
  assign portOn = portConfig.clockStopMode[SCS_MODE_ENABLE_BIT] & ~portConfig.txClockPolarity;
  assign modeFall = portConfig.clockStopMode[SCS_MODE_FALL_BIT];
  assign isMaster = portOn & portConfig.txClockDirection & portConfig.txSyncDirection
                    & ~portConfig.rxClockDirection & ~portConfig.rxSyncDirection;
  assign isSlave = portOn & ~portConfig.txClockDirection & ~portConfig.txSyncDirection
                   & ~portConfig.rxClockDirection & ~portConfig.rxSyncDirection;
  assign bothSyncPol = portConfig.txSyncPolarity & portConfig.rxSyncPolarity;

  // ---------------- Sample-rate generator ----------------
  logic refPrev;
  logic halfTick;
  logic [DW:0] halfCnt;
  logic [DW:0] lastHalf;
  logic [DW:0] highHalves;
  logic [DW:0] nextHalf;
  logic divEvenNz;
  logic genClk;
  logic genRise;
  logic genFall;

  // Reference pin sampled for edge detection; inputs are synchronous
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      refPrev <= 1'h0;
    end else begin
      refPrev <= srgRefClockIn;
    end
  end

  // Counting in half-S steps keeps odd and zero divides exact
  assign halfTick = (portConfig.srgSourceSelect == SCS_SRC_CPU) ? 1'h1
                    : (srgRefClockIn ^ refPrev);
  assign divEvenNz = ~portConfig.srgDivideValue[0] & (|portConfig.srgDivideValue);
  assign lastHalf = {portConfig.srgDivideValue, 1'h1};
  assign highHalves = {1'h0, portConfig.srgDivideValue}
                      + (divEvenNz ? (DW+1)'(SCS_HIGH_ADD_EVEN)
                                   : (DW+1)'(SCS_HIGH_ADD_ODD));
  assign nextHalf = (halfCnt >= lastHalf) ? '0 : halfCnt + (DW+1)'(1);
  assign genRise = halfTick & (nextHalf == '0);
  assign genFall = halfTick & (nextHalf == highHalves);

  // Free-running divider; the pin only sees it during a transfer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      halfCnt <= '0;
      genClk <= 1'h0;
    end else if (halfTick) begin
      halfCnt <= nextHalf;
      genClk <= (nextHalf < highHalves);
    end
  end

  // ---------------- Slave pin sampling ----------------
  logic slvClkPrev;
  logic selSlave;
  logic selRxSlave;
  assign selSlave = ~transmitFrameSyncIn;
  assign selRxSlave = ~receiveFrameSyncIn;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slvClkPrev <= 1'h0;
    end else begin
      slvClkPrev <= transmitBitClockIn;
    end
  end

  // Edge sources: own generator as master, pin as slave
  logic riseE;
  logic fallE;
  logic changeE;
  logic sampleE;
  assign riseE = isMaster ? genRise : (transmitBitClockIn & ~slvClkPrev);
  assign fallE = isMaster ? genFall : (~transmitBitClockIn & slvClkPrev);
  assign changeE = modeFall ? fallE : riseE;
  assign sampleE = modeFall ? riseE : fallE;

  // ---------------- Transfer sequencing ----------------
  scs_state_e state;
  logic [CW-1:0] bitCnt;
  logic masterStart;
  logic slaveStart;
  logic loadNow;
  logic leadDone;
  logic shiftDone;
  logic tailDone;
  logic inShift;
  logic shiftWin;

  // Master waits for a fall (10b) or a rise (11b) to open select
  assign masterStart = isMaster & (state == SCS_IDLE) & txValid
                       & (modeFall ? genRise : genFall);
  assign slaveStart = isSlave & (state == SCS_IDLE) & selSlave;
  assign loadNow = masterStart | slaveStart;
  assign txReady = masterStart | (slaveStart & txValid);
  assign inShift = (state == SCS_SHIFT);
  // In 11b the rise that ends the lead already samples the first bit
  assign shiftWin = inShift | leadDone;
  assign leadDone = (state == SCS_LEAD) & genRise;
  assign shiftDone = isMaster & inShift & (modeFall ? (genFall & (bitCnt == ALL_BITS))
                                                    : (genFall & (bitCnt == LAST_BIT)));
  assign tailDone = (state == SCS_TAIL) & (modeFall ? genRise : genFall);
  assign busy = (state != SCS_IDLE);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= SCS_IDLE;
    end else if (!isMaster && !(isSlave && selSlave)) begin
      state <= SCS_IDLE;
    end else begin
      case (state)
        SCS_IDLE: begin
          if (masterStart) begin
            state <= SCS_LEAD;
          end else if (slaveStart) begin
            state <= SCS_SHIFT;
          end
        end
        SCS_LEAD: begin
          if (leadDone) begin
            state <= SCS_SHIFT;
          end
        end
        SCS_SHIFT: begin
          if (shiftDone) begin
            state <= SCS_TAIL;
          end
        end
        SCS_TAIL: begin
          if (tailDone) begin
            state <= SCS_IDLE;
          end
        end
        default: begin
          state <= SCS_IDLE;
        end
      endcase
    end
  end

  // Samples taken in this word; saturates so stray slave clocks are ignored
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bitCnt <= '0;
    end else if (loadNow) begin
      bitCnt <= '0;
    end else if (shiftWin && sampleE && bitCnt < ALL_BITS) begin
      bitCnt <= bitCnt + CW'(1);
    end
  end

  // Master select and clock gate; clock only toggles in the shift state
  logic masterSel;
  logic clkGate;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      masterSel <= 1'h0;
      clkGate <= 1'h0;
    end else begin
      if (masterStart) begin
        masterSel <= 1'h1;
      end else if (tailDone || !isMaster) begin
        masterSel <= 1'h0;
      end
      if (leadDone && isMaster) begin
        clkGate <= 1'h1;
      end else if (shiftDone || !isMaster) begin
        clkGate <= 1'h0;
      end
    end
  end

  assign transmitBitClockOut.value = genClk & clkGate;
  assign transmitBitClockOut.enable = portConfig.txClockDirection;
  assign transmitFrameSyncOut.value = bothSyncPol ? ~masterSel : masterSel;
  assign transmitFrameSyncOut.enable = portConfig.txSyncDirection;

  // ---------------- Transmit data path ----------------
  logic [WORD_WIDTH-1:0] txShift;
  logic needShift;
  logic dataOn;
  logic dataOff;
  logic dataOe;
  logic [SCS_DELAY_CNT_WIDTH-1:0] delayCnt;

  // First bit appears at the first rise (10b), the lead fall (11b), or on select
  assign dataOn = (isMaster & (state == SCS_LEAD) & (modeFall ? genFall : genRise))
                  | slaveStart;
  assign dataOff = (isMaster & (modeFall ? shiftDone : ((state == SCS_TAIL) & genRise)))
                   | (isSlave & ~selSlave) | ~portOn;

  // Shift only after a sample, so the first change edge keeps bit one
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txShift <= '0;
      needShift <= 1'h0;
    end else if (loadNow) begin
      txShift <= txValid ? txData : '0;
      needShift <= 1'h0;
    end else if (shiftWin) begin
      if (changeE && needShift) begin
        txShift <= {txShift[WORD_WIDTH-2:0], 1'h0};
        needShift <= 1'h0;
      end else if (sampleE) begin
        needShift <= 1'h1;
      end
    end
  end

  // Enable lags by the extra delay for the first bit only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dataOe <= 1'h0;
      delayCnt <= '0;
    end else if (dataOff) begin
      dataOe <= 1'h0;
      delayCnt <= '0;
    end else if (dataOn) begin
      if (portConfig.txExtraDelayEnable) begin
        delayCnt <= SCS_DELAY_CNT_WIDTH'(SCS_EXTRA_DELAY_CYCLES);
      end else begin
        dataOe <= 1'h1;
      end
    end else if (delayCnt != '0) begin
      delayCnt <= delayCnt - SCS_DELAY_CNT_WIDTH'(1);
      if (delayCnt == SCS_DELAY_CNT_WIDTH'(1)) begin
        dataOe <= 1'h1;
      end
    end
  end

  assign serialDataOut.value = txShift[WORD_WIDTH-1];
  assign serialDataOut.enable = dataOe;

  // ---------------- Receive data path ----------------
  logic [WORD_WIDTH-1:0] rxShift;
  logic rxTake;
  // A slave listens only while its receive select is also active
  assign rxTake = shiftWin & sampleE & (bitCnt < ALL_BITS) & (isMaster | selRxSlave);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rxShift <= '0;
      rxData <= '0;
      rxValid <= 1'h0;
    end else begin
      rxValid <= 1'h0;
      if (rxTake) begin
        rxShift <= {rxShift[WORD_WIDTH-2:0], serialDataIn};
        if (bitCnt == LAST_BIT) begin
          rxData <= {rxShift[WORD_WIDTH-2:0], serialDataIn};
          rxValid <= 1'h1;
        end
      end
    end
  end

endmodule : scs_spi_port

// *** scs_spi_port_assertions.sv ***
// Pin-level checks for the clock-stop serial port
`timescale 1ns/10ps
module scs_spi_port_assertions
  import scs_pkg::*;
#(
  parameter int WORD_WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire scs_pkg::scs_config_s portConfig,
  input wire logic srgRefClockIn,
  input wire logic [WORD_WIDTH-1:0] txData,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic [WORD_WIDTH-1:0] rxData,
  input wire logic rxValid,
  input wire logic busy,
  input wire logic transmitBitClockIn,
  input wire scs_pkg::scs_pin_out_s transmitBitClockOut,
  input wire logic transmitFrameSyncIn,
  input wire scs_pkg::scs_pin_out_s transmitFrameSyncOut,
  input wire logic receiveFrameSyncIn,
  input wire scs_pkg::scs_pin_out_s serialDataOut,
  input wire logic serialDataIn
);
  logic ck, mst, slv, pol, cpu1, cpu2;
  // Role decode; invalid modes clear the master role only, the slave decode ignores the mode
  assign ck = transmitBitClockOut.value;
  assign pol = portConfig.rxSyncPolarity & portConfig.txSyncPolarity;
  assign mst = portConfig.txClockDirection & portConfig.txSyncDirection
    & ~portConfig.rxClockDirection & ~portConfig.rxSyncDirection
    & portConfig.clockStopMode[1] & ~portConfig.txClockPolarity;
  assign slv = ~(portConfig.txClockDirection | portConfig.txSyncDirection
    | portConfig.rxClockDirection | portConfig.rxSyncDirection);
  assign cpu1 = portConfig.srgSourceSelect & (portConfig.srgDivideValue == 8'h01);
  assign cpu2 = portConfig.srgSourceSelect & (portConfig.srgDivideValue == 8'h02);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_take; txReady |-> txValid && !busy; endproperty
  a_take: assert property (p_take) else $error("word taken while busy");
  property p_odd; mst && cpu1 && $rose(ck) |-> ck [*2] ##1 !ck; endproperty
  a_odd: assert property (p_odd) else $error("odd divide high phase");
  property p_oddl; mst && cpu1 && $fell(ck) |-> !ck [*2]; endproperty
  a_oddl: assert property (p_oddl) else $error("odd divide low phase");
  property p_even; mst && cpu2 && $rose(ck) |-> ck [*4] ##1 !ck [*2]; endproperty
  a_even: assert property (p_even) else $error("even divide phases");
  property p_stop; !busy && !$past(busy) |-> !ck && !serialDataOut.enable; endproperty
  a_stop: assert property (p_stop) else $error("clock or data active while idle");
  property p_dirs; !$past(rst) && $stable(portConfig) |->
    transmitBitClockOut.enable == portConfig.txClockDirection
    && transmitFrameSyncOut.enable == portConfig.txSyncDirection; endproperty
  a_dirs: assert property (p_dirs) else $error("pin direction mismatch");
  property p_selidle; mst && pol && !busy && !$past(busy) |-> transmitFrameSyncOut.value;
  endproperty
  a_selidle: assert property (p_selidle) else $error("select not high at idle");
  property p_lead; mst && pol && $fell(transmitFrameSyncOut.value) |-> !ck; endproperty
  a_lead: assert property (p_lead) else $error("select fell with clock high");
  property p_slvrel; slv && $rose(transmitFrameSyncIn) |-> ##[1:2] !serialDataOut.enable;
  endproperty
  a_slvrel: assert property (p_slvrel) else $error("slave data not released");
endmodule : scs_spi_port_assertions

bind scs_spi_port scs_spi_port_assertions #(.WORD_WIDTH(WORD_WIDTH)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .portConfig(portConfig), .srgRefClockIn(srgRefClockIn),
  .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData),
  .rxValid(rxValid), .busy(busy), .transmitBitClockIn(transmitBitClockIn),
  .transmitBitClockOut(transmitBitClockOut), .transmitFrameSyncIn(transmitFrameSyncIn),
  .transmitFrameSyncOut(transmitFrameSyncOut), .receiveFrameSyncIn(receiveFrameSyncIn),
  .serialDataOut(serialDataOut), .serialDataIn(serialDataIn));

// *** scs_spi_partner.sv ***
// Behavioural SPI slave facing the port in master role
`timescale 1ns/10ps
module scs_spi_partner (
  input wire logic clk_sys,
  input wire logic sclk,
  input wire logic selN,
  input wire logic mosi,
  input wire logic fallMode,
  input wire logic [7:0] reply,
  output logic miso,
  output logic [7:0] got
);
  logic lastClk = 1'b0;
  logic seen = 1'b0;
  logic junk = 1'b0;
  logic [7:0] sh = 8'h00;
  logic sampleEdge, shiftEdge;
  // Sample on fall in 10b, on rise in 11b; shift on the other edge
  assign sampleEdge = fallMode ? (sclk & ~lastClk) : (~sclk & lastClk);
  assign shiftEdge = fallMode ? (~sclk & lastClk) : (sclk & ~lastClk);
  // Deselected line toggles so a stale bit cannot pass
  assign miso = selN ? junk : sh[7];
  always @(posedge clk_sys) begin
    lastClk <= sclk;
    junk <= ~junk;
    if (selN) begin
      seen <= 1'b0;
      sh <= reply;
    end else if (sampleEdge) begin
      got <= {got[6:0], mosi};
      seen <= 1'b1;
    end else if (shiftEdge && seen) begin
      sh <= {sh[6:0], 1'b0};
    end
  end
endmodule : scs_spi_partner

// *** scs_spi_port_test.sv ***
// Self-checking bench for the clock-stop serial port
`timescale 1ns/10ps
module scs_spi_port_test;
  import scs_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  scs_config_s cfg = '0;
  logic refClk = 1'b0;
  logic [7:0] txData = 8'h00;
  logic [7:0] reply = 8'h00;
  logic txValid = 1'b0;
  logic bitClkIn = 1'b0;
  logic selIn = 1'b1;
  logic sdIn = 1'b0;
  logic slvMode = 1'b0;
  logic txReady, rxValid, busy, miso, latRun;
  logic [7:0] rxData, slvGot;
  scs_pin_out_s clkOut, syncOut, sdOut;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int lat = 0;
  int lat0 = 0;
  int rxPulses = 0;
  scs_spi_port dut (.clk_sys(clk_sys), .rst(rst), .portConfig(cfg), .srgRefClockIn(refClk),
    .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData),
    .rxValid(rxValid), .busy(busy), .transmitBitClockIn(bitClkIn),
    .transmitBitClockOut(clkOut), .transmitFrameSyncIn(selIn),
    .transmitFrameSyncOut(syncOut), .receiveFrameSyncIn(selIn), .serialDataOut(sdOut),
    .serialDataIn(slvMode ? sdIn : miso));
  scs_spi_partner u_slave (.clk_sys(clk_sys), .sclk(clkOut.value), .selN(syncOut.value),
    .mosi(sdOut.enable ? sdOut.value : ~sdOut.value), .fallMode(cfg.clockStopMode[0]),
    .reply(reply), .miso(miso),
    .got(slvGot));
  initial forever #5 clk_sys = ~clk_sys;
  // Timeout, reference clock at a sixth of the rate, first-bit latency
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (rxValid === 1'b1) rxPulses <= rxPulses + 1;
    if (cyc % 3 == 0) refClk <= ~refClk;
    if (txReady === 1'b1) latRun <= 1'b1;
    if (txReady === 1'b1) lat <= 0;
    else if (sdOut.enable === 1'b1) latRun <= 1'b0;
    else if (latRun === 1'b1) lat <= lat + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic cmpWord(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmpWord
  task automatic cmpBit(input logic got, input logic exp);
    cmpWord({7'h00, got}, {7'h00, exp});
  endtask : cmpBit
  // Master transfer against the partner slave
  task automatic master_xfer(input logic [1:0] mode, input logic [7:0] div, input logic src,
      input logic ext, input logic [7:0] w, input logic [7:0] r);
    @(posedge clk_sys);
    cfg <= '{src, div, ext, mode, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    reply <= r;
    txData <= w;
    txValid <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      #1;
      if (txReady === 1'b1) break;
      @(posedge clk_sys);
    end
    @(posedge clk_sys);
    txValid <= 1'b0;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      #1;
      if (busy !== 1'b1) break;
    end
    cmpWord(slvGot, w);
    cmpWord(rxData, r);
    cmpBit(syncOut.value, 1'b1);
  endtask : master_xfer
  // Slave transfer in either clock-stop mode, the bench acting as master
  task automatic slave_xfer(input logic [1:0] mode, input logic [7:0] w, input logic [7:0] r);
    logic [7:0] got;
    @(posedge clk_sys);
    slvMode <= 1'b1;
    cfg <= '{1'b1, 8'h01, 1'b0, mode, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    txData <= w;
    txValid <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cmpBit(busy, 1'b0);
    selIn <= 1'b0;
    sdIn <= r[7];
    repeat (3) @(posedge clk_sys);
    txValid <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      bitClkIn <= 1'b1;
      sdIn <= r[i];
      repeat (4) @(posedge clk_sys);
      // A released line reads as the inverse, so late enables show up
      got[i] = sdOut.enable ? sdOut.value : ~sdOut.value;
      bitClkIn <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    cmpWord(got, w);
    cmpWord(rxData, r);
    selIn <= 1'b1;
    sdIn <= ~sdIn;
    repeat (3) @(posedge clk_sys);
    cmpBit(sdOut.enable, 1'b0);
  endtask : slave_xfer
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    // Same divide for both, with a high phase long enough for the delayed bit
    master_xfer(2'h2, 8'h03, 1'b1, 1'b0, 8'ha5, 8'h3c);
    lat0 = lat;
    master_xfer(2'h2, 8'h03, 1'b1, 1'b1, 8'h81, 8'h7e);
    cmpBit(lat - lat0 >= 2 && lat - lat0 <= 4, 1'b1);
    master_xfer(2'h3, 8'h01, 1'b1, 1'b0, 8'h5a, 8'hc3);
    master_xfer(2'h3, 8'h02, 1'b1, 1'b0, 8'hf0, 8'h0f);
    master_xfer(2'h2, 8'h00, 1'b0, 1'b0, 8'h69, 8'h96);
    slave_xfer(2'h2, 8'hc6, 8'h39);
    slave_xfer(2'h3, 8'h5c, 8'h93);
    cmpWord(8'(rxPulses), 8'h07);
    conclude();
  end
endmodule : scs_spi_port_test
